/* logic/fcr_regs.svh */
// Register indexes, field positions, reset values and timing counts for the floppy config bank
`ifndef FCR_REGS_SVH
`define FCR_REGS_SVH
`define FCR_IDX_ACTIVATE      8'h30
`define FCR_IDX_CTRL_CONFIG   8'hF0
`define FCR_IDX_DRIVE_IDENTIFICATION      8'hF1
`define FCR_RST_ACTIVATE      8'h00
`define FCR_RST_CTRL_CONFIG   8'h24
`define FCR_RST_DRIVE_IDENTIFICATION      8'h00
`define FCR_CFG_TAPE_MODE     6
`define FCR_CFG_DENS_POL      5
`define FCR_CFG_WPROT         3
`define FCR_CFG_DRV_MODE      2
`define FCR_CFG_FLOAT         0
`define FCR_CFG_WMASK         8'h6D
`define FCR_DID_WMASK         8'h0F
`define FCR_ACT_WMASK         8'h01
`define FCR_SYNC_STAGES       3
`define FCR_TAPE_ONES         6'h3F
`endif

/* logic/fcr_pkg.sv */
// Types shared by the floppy config bank
package fcr_pkg;
	typedef enum logic {
		fcr_alternate_drive_mode,
		fcr_legacy_at_drive_mode
	} fcr_drive_mode_t;
endpackage

/* logic/fcr_sync.sv */
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`include "fcr_regs.svh"
module fcr_sync #(
	parameter int STAGES      = `FCR_SYNC_STAGES,
	parameter bit RESET_LEVEL = 1'b0
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic async_in,
	output logic      sync_out
);
	logic [STAGES-1:0] stage;
	wire               agree = (stage[STAGES-1] == stage[STAGES-2]);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stage <= {STAGES{RESET_LEVEL}};
		end else begin
			stage <= {stage[STAGES-2:0], async_in};
		end
	end

	// Filtered output held until the last two stages match; reset is a constant
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync_out <= RESET_LEVEL;
		end else if (agree) begin
			sync_out <= stage[STAGES-1];
		end
	end
endmodule

/* logic/fcr_top.sv */
// Floppy controller configuration register bank with tape-drive read-back and pin controls
//
// Functional notes
// R1: Software writes zero to config bits 7, 4
// R2: Mode bit clear: tape bits 7-2 read ones
// R3: Mode bit set: bits 5-4 from drive_identification
// R4: Bit 5 sets density output polarity
// R5: Bit 3 forces write protection
// R6: Bit 2 picks alternate or legacy mode
// R7: Bit 0 floats pins while device inactive
// R8: Config register resets to 24h
// R9: Drive_identification resets 00h, bits 7-4 reserved
// R10: Drive 1 shows ID bits 3-2
// R11: Drive 0 shows ID bits 1-0
// R12: Software sets ID bit without media sense
// R13: Activate register at 30h gates floating
// R14: Reserved drive_identification bits ignored, read zero
`timescale 1ns/1ps
`include "fcr_regs.svh"
module fcr_top
	import fcr_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [7:0] cfg_index,
	input  wire logic [7:0] cfg_wdata,
	input  wire logic       cfg_wr,
	input  wire logic       cfg_rd,
	output logic      [7:0] cfg_rdata,
	output logic            cfg_hit,
	input  wire logic       drive_sel,
	input  wire logic [1:0] tape_drive_low,
	input  wire logic       high_rate,
	input  wire logic       write_protect_n,
	output logic      [5:0] tape_drive_reg_high,
	output logic            density_select_out,
	output logic            write_blocked,
	output logic            legacy_at_drive_mode,
	output logic            pins_float,
	output logic            device_active
);
	////////////////////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0]      floppy_controller_config;
	logic [7:0]      drive_identification;
	logic [7:0]      activate;
	logic            wp_sync;
	fcr_drive_mode_t next_mode;

	wire sel_cfg = (cfg_index == `FCR_IDX_CTRL_CONFIG);
	wire sel_did = (cfg_index == `FCR_IDX_DRIVE_IDENTIFICATION);
	wire sel_act = (cfg_index == `FCR_IDX_ACTIVATE);
	wire wr_cfg  = cfg_wr && sel_cfg;
	wire wr_did  = cfg_wr && sel_did;
	wire wr_act  = cfg_wr && sel_act;

	// Reserved config bits are dropped on write so a stray one cannot steer logic [R1]
	wire [7:0] next_config = cfg_wdata & `FCR_CFG_WMASK;
	wire [7:0] next_did    = cfg_wdata & `FCR_DID_WMASK; // [R14]
	wire [7:0] next_act    = cfg_wdata & `FCR_ACT_WMASK;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Configuration storage
	// Index decode above is shared by the read mux and the write enables
	// Writes take effect at the strobe edge with no shadow copy, so a half-written
	// setup is visible on the pins straight away
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			floppy_controller_config <= `FCR_RST_CTRL_CONFIG; // [R8]
		end else if (wr_cfg) begin
			floppy_controller_config <= next_config;
		end
	end

	// Drive identification; the upper nibble can never hold a one
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			drive_identification <= `FCR_RST_DRIVE_IDENTIFICATION; // [R9]
		end else if (wr_did) begin
			drive_identification <= next_did; // [R9]
		end
	end

	// Activate register; only bit 0 is stored, so the rest read back as zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			activate <= `FCR_RST_ACTIVATE; // [R13]
		end else if (wr_act) begin
			activate <= next_act;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Write-protect pin comes from the drive cable, so it is synchronised first
	// The pin idles high, so its inverse rests at the synchroniser's reset level
	// Pin-to-output latency is a handful of clocks, far shorter than any write
	fcr_sync #(
		.STAGES      (`FCR_SYNC_STAGES),
		.RESET_LEVEL (1'b0)
	) u_wp_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in (~write_protect_n),
		.sync_out (wp_sync)
	);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Decoded behaviour
	wire       enhanced   = floppy_controller_config[`FCR_CFG_TAPE_MODE];
	wire       dens_pol   = floppy_controller_config[`FCR_CFG_DENS_POL];
	wire       force_wp   = floppy_controller_config[`FCR_CFG_WPROT];
	wire       float_en   = floppy_controller_config[`FCR_CFG_FLOAT];
	wire       active     = activate[0];
	// Drive select picks which ID pair is reflected
	wire [1:0] id_pair    = drive_sel ? drive_identification[3:2] // [R10]
	                                  : drive_identification[1:0]; // [R11]
	// Enhanced mode reflects the ID pair; normal mode masks it with ones
	// Bits 7-6 stay ones in enhanced mode too; only bits 5-4 carry the ID
	wire [5:0] next_tape  = enhanced ? {2'b11, id_pair, tape_drive_low} // [R3]
	                                 : `FCR_TAPE_ONES; // [R2]
	// Density is active at the high rates; polarity bit chooses the driven level
	// Limitation: no setting holds the output at one fixed level at all rates
	wire       next_dens  = high_rate ? dens_pol : ~dens_pol; // [R4]
	wire       next_wblk  = force_wp | wp_sync; // [R5]
	wire       next_float = float_en & ~active; // [R7]
	// Unmapped indexes read zero and raise no hit
	wire [7:0] next_rdata = sel_cfg ? floppy_controller_config
	                      : sel_did ? drive_identification
	                      : sel_act ? activate
	                      : 8'h00;
	// Hit covers writes as well, so software can probe an index without reading
	wire       next_hit   = (cfg_rd | cfg_wr) & (sel_cfg | sel_did | sel_act);

	// A cleared mode bit selects the alternate drive interface
	assign next_mode = floppy_controller_config[`FCR_CFG_DRV_MODE] ? // [R6]
	                   fcr_legacy_at_drive_mode : fcr_alternate_drive_mode;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Bus-facing outputs; one cycle of latency is traded for glitch-free pins
	// Read data is zero outside a read so a stale value never lingers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_rdata <= 8'h00;
		end else begin
			cfg_rdata <= cfg_rd ? next_rdata : 8'h00;
		end
	end

	// Hit flags a mapped index on either strobe
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_hit <= 1'b0;
		end else begin
			cfg_hit <= next_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Pin-facing outputs
	// Tape-drive bits 7-2; reset shows the normal all-ones pattern
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tape_drive_reg_high <= `FCR_TAPE_ONES;
		end else begin
			tape_drive_reg_high <= next_tape; // [R3]
		end
	end

	// Density select
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			density_select_out <= 1'b0;
		end else begin
			density_select_out <= next_dens; // [R4]
		end
	end

	// Forced protection and the synchronised pin both block writes
	// The force bit acts at once; the pin waits out the synchroniser
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			write_blocked <= 1'b0;
		end else begin
			write_blocked <= next_wblk; // [R5]
		end
	end

	// Registered from the decoded mode so the pin moves with the others
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			legacy_at_drive_mode <= 1'b1;
		end else begin
			legacy_at_drive_mode <= (next_mode == fcr_legacy_at_drive_mode); // [R6]
		end
	end

	// Floating is only requested here; the pad ring owns the output enables
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pins_float <= 1'b0;
		end else begin
			pins_float <= next_float; // [R13]
		end
	end

	// Mirrors activate bit 0 so pad logic need not decode the index space
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			device_active <= 1'b0;
		end else begin
			device_active <= active; // [R13]
		end
	end
endmodule

/* dv/fcr_drive_model.sv */
// Drive-side model for the select and write-protect pins
`timescale 1ns/1ps
module fcr_drive_model (
	input  wire logic clk_sys,
	input  wire logic sel_req,
	input  wire logic wp_req,
	output logic      drive_sel,
	output logic      write_protect_n
);
	// Pins move just after an edge, as a cabled drive would
	always @(posedge clk_sys) begin
		drive_sel <= sel_req;
		write_protect_n <= ~wp_req;
	end
endmodule

/* dv/fcr_top_asserts.sv */
// Port checker for the floppy config bank
`timescale 1ns/1ps
module fcr_top_asserts (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic [7:0] cfg_index,
	input wire logic [7:0] cfg_wdata,
	input wire logic       cfg_wr,
	input wire logic       cfg_rd,
	input wire logic [7:0] cfg_rdata,
	input wire logic       cfg_hit,
	input wire logic       high_rate,
	input wire logic [5:0] tape_drive_reg_high,
	input wire logic       density_select_out,
	input wire logic       write_blocked,
	input wire logic       legacy_at_drive_mode,
	input wire logic       pins_float,
	input wire logic       device_active
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Two idle cycles let the slowest output settle
	sequence wr_cfg_s;
		cfg_wr && cfg_index == 8'hF0 ##1 !cfg_wr [*2];
	endsequence
	tape_normal_a: assert property (wr_cfg_s |=>
		$past(cfg_wdata[6], 3) || tape_drive_reg_high == 6'h3F)
		else $error("tape bits not ones");
	dens_pol_a: assert property (wr_cfg_s |=>
		density_select_out == ($past(high_rate) ~^ $past(cfg_wdata[5], 3)))
		else $error("density polarity");
	wp_force_a: assert property (wr_cfg_s ##0 $past(cfg_wdata[3], 2) |=>
		write_blocked)
		else $error("write not blocked");
	drive_mode_a: assert property (wr_cfg_s |=>
		legacy_at_drive_mode == $past(cfg_wdata[2], 3))
		else $error("drive mode");
	float_gate_a: assert property (pins_float |-> !device_active)
		else $error("float while active");
	reset_out_a: assert property ($past(rst) |->
		legacy_at_drive_mode && !pins_float)
		else $error("reset outputs");
	id_rsvd_a: assert property (cfg_rd && cfg_index == 8'hF1 |=>
		cfg_hit && cfg_rdata[7:4] == 4'h0)
		else $error("id reserved");
	cfg_rsvd_a: assert property (cfg_rd && cfg_index == 8'hF0 |=>
		cfg_hit && (cfg_rdata & 8'h92) == 8'h00)
		else $error("cfg reserved");
endmodule
bind fcr_top fcr_top_asserts chk (.*);

/* dv/fcr_top_tb.sv */
// Self-checking bench for the floppy config bank
`timescale 1ns/1ps
`define CHK(a, b) \
	begin \
		n_compared++; \
		if ((a) !== (b)) begin \
			n_errors++; \
			$display("[ERR] %0t %h %h", $time, (a), (b)); \
		end \
	end
module fcr_top_tb;
	logic clk_sys = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, high_rate = 1, sel_req = 0, wp_req = 0;
	logic [7:0] cfg_index = 8'h00, cfg_wdata = 8'h00, cfg_rdata, c, d, a;
	logic [1:0] tape_drive_low = 2'h0;
	logic [5:0] tape_drive_reg_high;
	logic cfg_hit, drive_sel, write_protect_n, density_select_out, write_blocked;
	logic legacy_at_drive_mode, pins_float, device_active;
	int n_errors = 0, n_compared = 0;
	always #12.5 clk_sys = ~clk_sys;
	fcr_top dut (.*);
	fcr_drive_model fdd (.*);
	////////////////////////////////
	task automatic wr(input logic [7:0] i, input logic [7:0] v);
		@(posedge clk_sys);
		cfg_index <= i;
		cfg_wdata <= v;
		cfg_wr <= 1'b1;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] v, input logic h);
		@(posedge clk_sys);
		cfg_index <= i;
		cfg_rd <= 1'b1;
		@(posedge clk_sys);
		cfg_rd <= 1'b0;
		#1;
		`CHK(cfg_rdata, v)
		`CHK(cfg_hit, h)
	endtask
	function automatic logic [5:0] exp_tape(input logic [7:0] c, d, input logic s,
	                                        input logic [1:0] l);
		return c[6] ? {2'b11, s ? d[3:2] : d[1:0], l} : 6'h3F;
	endfunction
	task automatic conclude();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	////////////////////////////////
	initial begin
		void'($urandom(33));
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		rd(8'hF0, 8'h24, 1);
		rd(8'hF1, 8'h00, 1);
		rd(8'h55, 8'h00, 0);
		`CHK({legacy_at_drive_mode, density_select_out, tape_drive_reg_high}, 8'hFF)
		wr(8'hF0, 8'h6F);
		rd(8'hF0, 8'h6D, 1);
		wr(8'hF1, 8'hFF);
		rd(8'hF1, 8'h0F, 1);
		for (int k = 0; k < 24; k++) begin
			c = 8'($urandom) & 8'h6D;
			d = 8'($urandom) & 8'h0F;
			a = 8'($urandom) & 8'h01;
			wr(8'hF1, d);
			wr(8'h30, a);
			// Config goes last and is followed by idle cycles, so the checker sees it
			wr(8'hF0, c);
			{high_rate, sel_req, wp_req, tape_drive_low} <= 5'($urandom);
			// Write-protect crosses a synchroniser, so allow it time
			repeat (8) @(posedge clk_sys);
			#1;
			`CHK(tape_drive_reg_high, exp_tape(c, d, sel_req, tape_drive_low))
			`CHK(density_select_out, high_rate ~^ c[5])
			`CHK(write_blocked, c[3] | wp_req)
			`CHK(legacy_at_drive_mode, c[2])
			`CHK({pins_float, device_active}, {c[0] & ~a[0], a[0]})
		end
		// Reset again in mid-run; every register must return to its reset value
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rd(8'hF0, 8'h24, 1);
		rd(8'hF1, 8'h00, 1);
		rd(8'h30, 8'h00, 1);
		// Drives without media sense get ID bits 1 and 3 set by software
		wr(8'hF1, 8'h0A);
		wr(8'hF0, 8'h64);
		for (int s = 0; s < 2; s++) begin
			sel_req <= s[0];
			repeat (4) @(posedge clk_sys);
			#1;
			`CHK(tape_drive_reg_high[3:2], 2'b10)
		end
		conclude();
	end
	// Run needs about 375 cycles; cut off well beyond that
	initial begin
		#150000;
		n_errors++;
		conclude();
	end
endmodule
